// [hdl/rsw_defs.svh]
// Constants for the reset sequencer and digital watchdog
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH

`define RSW_WDOG_ADDR 8'hd8
`define RSW_WDOG_RESET 8'hfe
`define RSW_BIT_ARM 0
`define RSW_BIT_SOFTRST 1
`define RSW_CNT_RESET 7'h7f
`define RSW_CNT_MSB 6
`define RSW_CNT_FALL 7'h40
`define RSW_PERIOD_BITS 6
`define RSW_REG_MSB 7
`define RSW_STAB_CYCLES 2048
`define RSW_STAB_LAST 11'h7ff
`define RSW_DIV_LAST 4'hb
`define RSW_PRE_LAST 8'hff
`define RSW_RESET_VECTOR 12'hffe

`endif

// [hdl/rsw_pkg.sv]
// Types shared by the reset sequencer and digital watchdog
package rsw_pkg;

  typedef enum logic [1:0] {
    RSW_HOLD = 2'b00,
    RSW_DELAY = 2'b01,
    RSW_RUN = 2'b10
  } rsw_state_t;

  // Core access to the watchdog register in data space
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } rsw_regreq_t;

  // Start-up commands toward the core
  typedef struct packed {
    logic loadVector;
    logic stackClear;
    logic [11:0] vector;
  } rsw_boot_t;

endpackage

// [hdl/rsw_reset_sequencer_and_watchdog.sv]
// Reset sequencer with stabilisation delay and digital watchdog
`timescale 1ns/1ps
`include "rsw_defs.svh"

module rsw_reset_sequencer_and_watchdog
  import rsw_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic extResetN,
  input wire logic hwOptionStrap,
  input wire rsw_regreq_t regReq,
  output logic [7:0] regRdData,
  input wire logic stopRequest,
  input wire logic wakeInterrupt,
  input wire logic interruptReturnOp,
  input wire logic pendingInterrupt,
  output logic coreResetN,
  output logic ioPullupForce,
  output rsw_boot_t boot,
  output logic nmiContext,
  output logic serviceInterrupt,
  output logic continueNext,
  output logic oscHalt,
  output logic stopAsWait,
  output logic wdogArmed,
  output logic wdogResetEvent
);

  // Sequencer state
  rsw_state_t state_q;
  rsw_state_t state_d;
  logic [10:0] stabCnt_q;
  logic [10:0] stabCnt_d;
  logic hwOpt_q;
  logic hwOpt_d;
  rsw_boot_t boot_q;
  rsw_boot_t boot_d;
  logic nmiCtx_q;
  logic nmiCtx_d;
  logic svc_q;
  logic svc_d;
  logic cont_q;
  logic cont_d;

  // Clock divider and prescaler
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic [7:0] pre_q;
  logic [7:0] pre_d;

  // Watchdog state; counter bit 0 is the period LSB, bit 6 the soft reset bit
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic arm_q;
  logic arm_d;
  logic stopped_q;
  logic stopped_d;
  logic wdReset_q;
  logic wdReset_d;
  logic [7:0] rd_q;
  logic [7:0] rd_d;

  logic running;
  logic wdInit;
  logic regHit;
  logic wrHit;
  logic divTick;
  logic stepTick;
  logic countEn;
  logic fallReset;
  logic softReset;
  logic [7:0] regView;
  logic [6:0] wrCnt;

  assign running = (state_q == RSW_RUN);
  // Pin or watchdog reset: the core is held either way
  assign wdInit = !running || wdReset_q;
  assign regHit = (regReq.addr == `RSW_WDOG_ADDR);
  // Writes while the core is held are dropped
  assign wrHit = !wdInit && regReq.wrEn && regHit;

  // Map between the register layout and the physical counter
  genvar gi;
  generate
    for (gi = 0; gi < `RSW_PERIOD_BITS; gi++) begin : g_period
      assign regView[`RSW_REG_MSB - gi] = cnt_q[gi];
      assign wrCnt[gi] = regReq.wrData[`RSW_REG_MSB - gi];
    end
  endgenerate
  assign regView[`RSW_BIT_SOFTRST] = cnt_q[`RSW_CNT_MSB];
  assign regView[`RSW_BIT_ARM] = arm_q;
  assign wrCnt[`RSW_CNT_MSB] = regReq.wrData[`RSW_BIT_SOFTRST];

  // Soft reset bit falling through the count ends the period when armed
  assign fallReset = stepTick && arm_q && !wrHit &&
                     (cnt_q == `RSW_CNT_FALL);
  // A write that clears the soft reset bit resets at once
  assign softReset = wrHit && !regReq.wrData[`RSW_BIT_SOFTRST];

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    stabCnt_d = stabCnt_q;
    hwOpt_d = hwOpt_q;
    boot_d = boot_q;
    boot_d.loadVector = 1'b0;
    nmiCtx_d = nmiCtx_q;
    svc_d = 1'b0;
    cont_d = 1'b0;
    unique case (state_q)
      RSW_HOLD: begin
        // Strap sampled while the core is held
        hwOpt_d = hwOptionStrap;
        stabCnt_d = '0;
        if (extResetN) begin
          state_d = RSW_DELAY;
        end
      end
      RSW_DELAY: begin
        hwOpt_d = hwOptionStrap;
        if (!extResetN) begin
          state_d = RSW_HOLD;
        end else if (stabCnt_q == `RSW_STAB_LAST) begin
          state_d = RSW_RUN;
          boot_d.loadVector = 1'b1;
          boot_d.stackClear = 1'b0;
        end else begin
          stabCnt_d = stabCnt_q + 11'h001;
        end
      end
      RSW_RUN: begin
        if (!extResetN) begin
          state_d = RSW_HOLD;
        end else if (wdReset_q) begin
          state_d = RSW_DELAY;
          stabCnt_d = '0;
        end
        // No context switch in the cycle the watchdog holds the core
        if (interruptReturnOp && nmiCtx_q && !wdReset_q) begin
          nmiCtx_d = 1'b0;
          svc_d = pendingInterrupt;
          cont_d = !pendingInterrupt;
        end
      end
      default: begin
        state_d = RSW_HOLD;
      end
    endcase
    // Reset state must show in the same cycle the watchdog pulls the core
    if ((state_d != RSW_RUN) || wdReset_d) begin
      boot_d.stackClear = 1'b1;
      nmiCtx_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= RSW_HOLD;
      stabCnt_q <= '0;
      hwOpt_q <= 1'b0;
      boot_q <= '{loadVector: 1'b0, stackClear: 1'b1, vector: `RSW_RESET_VECTOR};
      nmiCtx_q <= 1'b1;
      svc_q <= 1'b0;
      cont_q <= 1'b0;
    end else begin
      state_q <= state_d;
      stabCnt_q <= stabCnt_d;
      hwOpt_q <= hwOpt_d;
      boot_q <= boot_d;
      nmiCtx_q <= nmiCtx_d;
      svc_q <= svc_d;
      cont_q <= cont_d;
    end
  end

  // Halted oscillator freezes counting; wait mode keeps it running
  assign countEn = !wdInit && !stopped_q;
  // Divide by twelve, then by 256: one counter step every 3072 cycles
  assign divTick = countEn && (div_q == `RSW_DIV_LAST);
  assign stepTick = divTick && (pre_q == `RSW_PRE_LAST);

  always_comb begin
    div_d = div_q;
    pre_d = pre_q;
    if (wdInit || wrHit) begin
      // A reload restarts the period from a clean divider phase
      div_d = '0;
      pre_d = '0;
    end else if (countEn) begin
      div_d = divTick ? 4'h0 : div_q + 4'h1;
      if (divTick) begin
        pre_d = pre_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
      pre_q <= '0;
    end else begin
      div_q <= div_d;
      pre_q <= pre_d;
    end
  end

  // Watchdog next state
  always_comb begin
    cnt_d = cnt_q;
    arm_d = arm_q;
    stopped_d = stopped_q;
    wdReset_d = 1'b0;
    if (wdInit) begin
      // Internal reset reinitialises the whole watchdog
      cnt_d = `RSW_CNT_RESET;
      arm_d = hwOpt_q;
      stopped_d = 1'b0;
    end else begin
      if (wrHit) begin
        cnt_d = wrCnt;
        // A write only ever sets arm; hardware option keeps it forced
        arm_d = arm_q | hwOpt_q | regReq.wrData[`RSW_BIT_ARM];
      end else if (stepTick) begin
        cnt_d = cnt_q - 7'h01;
      end
      // Stop halts the oscillator only when the watchdog cannot run
      // A halted core issues no writes, so arming never meets a halt
      if (stopRequest && !arm_q && !hwOpt_q) begin
        stopped_d = 1'b1;
      end else if (wakeInterrupt) begin
        stopped_d = 1'b0;
      end
      wdReset_d = fallReset || softReset;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= `RSW_CNT_RESET;
      arm_q <= 1'b0;
      stopped_q <= 1'b0;
      wdReset_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      arm_q <= arm_d;
      stopped_q <= stopped_d;
      wdReset_q <= wdReset_d;
    end
  end

  // Read data holds until the next read of the register
  always_comb begin
    rd_d = rd_q;
    if (regReq.rdEn && regHit) begin
      // Reads while the core is held return the reset value
      rd_d = wdInit ? `RSW_WDOG_RESET : regView;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= `RSW_WDOG_RESET;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign regRdData = rd_q;
  assign coreResetN = !wdInit;
  assign ioPullupForce = !coreResetN;
  assign boot = boot_q;
  assign nmiContext = nmiCtx_q;
  assign serviceInterrupt = svc_q;
  assign continueNext = cont_q;
  assign oscHalt = stopped_q;
  assign stopAsWait = running && hwOpt_q && stopRequest;
  assign wdogArmed = arm_q;
  assign wdogResetEvent = wdReset_q;

endmodule

// [tb/rsw_checker.sv]
// Port assertions for the reset sequencer and watchdog
`timescale 1ns/1ps
module rsw_checker
  import rsw_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic extResetN,
  input wire rsw_regreq_t regReq,
  input wire logic interruptReturnOp,
  input wire logic pendingInterrupt,
  input wire logic stopRequest,
  input wire logic hwOptionStrap,
  input wire logic coreResetN,
  input wire logic ioPullupForce,
  input wire rsw_boot_t boot,
  input wire logic nmiContext,
  input wire logic serviceInterrupt,
  input wire logic oscHalt,
  input wire logic stopAsWait,
  input wire logic wdogArmed,
  input wire logic wdogResetEvent
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [11:0] lowCnt_q;
  logic [11:0] lowCnt_d;
  // Pin reset restarts the count, watchdog reset does not
  always_comb begin
    lowCnt_d = lowCnt_q + 12'h001;
    if (coreResetN || !extResetN) lowCnt_d = 12'h000;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) lowCnt_q <= 12'h000;
    else lowCnt_q <= lowCnt_d;
  end
  a_pullup_tracks: assert property (ioPullupForce == !coreResetN)
    else $error("pull-up force wrong");
  a_stab_delay: assert property ($rose(coreResetN) |-> lowCnt_q >= 12'h800)
    else $error("delay too short");
  a_vector_load: assert property ($rose(coreResetN) |-> boot.loadVector && boot.vector == 12'hffe)
    else $error("no vector load");
  a_reset_state: assert property (!coreResetN |-> boot.stackClear && nmiContext)
    else $error("reset state wrong");
  a_ext_hold: assert property (!extResetN |=> !coreResetN)
    else $error("pin reset ignored");
  a_return_answer: assert property (interruptReturnOp && nmiContext && coreResetN |=>
    !nmiContext && serviceInterrupt == $past(pendingInterrupt)) else $error("bad return");
  a_soft_reset: assert property (regReq.wrEn && regReq.addr == 8'hd8 && !regReq.wrData[1]
    && coreResetN |=> wdogResetEvent && !coreResetN) else $error("no soft reset");
  a_arm_sticky: assert property ($fell(wdogArmed) |-> !coreResetN)
    else $error("arm dropped");
  a_stop_wait: assert property (hwOptionStrap && stopRequest && coreResetN |-> stopAsWait)
    else $error("stop not wait");
  a_armed_no_halt: assert property (wdogArmed |-> !oscHalt)
    else $error("halt while armed");
endmodule

bind rsw_reset_sequencer_and_watchdog rsw_checker chk (.*);

// [tb/rsw_core_model.sv]
// Core model reaching the watchdog register by data-space strobes
`timescale 1ns/1ps
module rsw_core_model
  import rsw_pkg::*;
(
  input wire logic clk,
  output rsw_regreq_t regReq,
  input wire logic [7:0] regRdData
);
  initial regReq = '0;
  // Callers keep bit 1 set unless a reset is wanted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    regReq = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // Idle bus shows inverted lines, never the last value
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk);
    regReq = '{1'b0, 1'b1, a, 8'h5a};
    @(negedge clk);
    regReq = '{1'b0, 1'b0, ~a, 8'ha5};
    q = regRdData;
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the reset sequencer and watchdog
`timescale 1ns/1ps
module tb_top
  import rsw_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic extResetN = 1'b1;
  logic hwOptionStrap = 1'b0;
  logic stopRequest = 1'b0;
  logic wakeInterrupt = 1'b0;
  logic interruptReturnOp = 1'b0;
  logic pendingInterrupt = 1'b0;
  rsw_regreq_t regReq;
  rsw_boot_t boot;
  logic [7:0] regRdData;
  logic [7:0] q;
  logic coreResetN, ioPullupForce, nmiContext, serviceInterrupt, continueNext;
  logic oscHalt, stopAsWait, wdogArmed, wdogResetEvent;
  int n_errors = 0;
  int num_checks = 0;
  int t;
  always #20 clk = ~clk;
  rsw_core_model core (.clk, .regReq, .regRdData);
  rsw_reset_sequencer_and_watchdog uut (.clk, .nrst, .extResetN, .hwOptionStrap, .regReq,
    .regRdData, .stopRequest, .wakeInterrupt, .interruptReturnOp, .pendingInterrupt,
    .coreResetN, .ioPullupForce, .boot, .nmiContext, .serviceInterrupt, .continueNext,
    .oscHalt, .stopAsWait, .wdogArmed, .wdogResetEvent);
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // Counts falling edges until the chosen output is high
  task automatic waitHi(input bit evt, input int lim, input bit must, output int n);
    n = 0;
    while ((evt ? wdogResetEvent : coreResetN) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (must && n == lim) begin
      chk(1'b0, "wait ran out");
      conclude();
    end
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    waitHi(0, 2100, 1, t);
    chk(t == 2049, "power-up delay");
    chk(boot.vector === 12'hffe && nmiContext === 1'b1, "start state");
    core.rd(8'hd8, q);
    chk(q === 8'hfe && wdogArmed === 1'b0, "reset value");
    pendingInterrupt = 1'b1;
    interruptReturnOp = 1'b1;
    @(negedge clk);
    interruptReturnOp = 1'b0;
    chk(serviceInterrupt === 1'b1 && nmiContext === 1'b0 && continueNext === 1'b0,
      "return");
    core.wr(8'hd8, 8'h02);
    core.rd(8'hd8, q);
    chk(q === 8'h02, "reload readback");
    core.rd(8'hd7, q);
    chk(q === 8'h02, "unmapped read");
    waitHi(1, 4000, 0, t);
    chk(t == 4000, "disarmed timer reset");
    core.rd(8'hd8, q);
    chk(q === 8'hfc, "timer count");
    stopRequest = 1'b1;
    repeat (2) @(negedge clk);
    chk(oscHalt === 1'b1, "no halt");
    stopRequest = 1'b0;
    wakeInterrupt = 1'b1;
    repeat (2) @(negedge clk);
    wakeInterrupt = 1'b0;
    chk(oscHalt === 1'b0, "no wake");
    core.wr(8'hd8, 8'h03);
    waitHi(1, 2000, 0, t);
    chk(t == 2000, "reset before end");
    core.wr(8'hd8, 8'h83);
    waitHi(1, 6200, 1, t);
    chk(t >= 6142 && t <= 6145, "timeout length");
    waitHi(0, 2100, 1, t);
    chk(t >= 2047 && t <= 2050, "watchdog restart");
    core.rd(8'hd8, q);
    chk(q === 8'hfe && wdogArmed === 1'b0, "reinit");
    core.wr(8'hd8, 8'h01);
    chk(wdogResetEvent === 1'b1 && coreResetN === 1'b0, "soft reset");
    repeat (100) @(negedge clk);
    extResetN = 1'b0;
    hwOptionStrap = 1'b1;
    repeat (3) @(negedge clk);
    extResetN = 1'b1;
    waitHi(0, 2100, 1, t);
    chk(t == 2049, "delay restart");
    core.wr(8'hd8, 8'h02);
    core.rd(8'hd8, q);
    chk(q === 8'h03 && wdogArmed === 1'b1, "arm forced");
    pendingInterrupt = 1'b0;
    interruptReturnOp = 1'b1;
    @(negedge clk);
    interruptReturnOp = 1'b0;
    chk(continueNext === 1'b1 && serviceInterrupt === 1'b0 && nmiContext === 1'b0,
      "plain return");
    stopRequest = 1'b1;
    @(negedge clk);
    chk(stopAsWait === 1'b1 && oscHalt === 1'b0, "stop as wait");
    stopRequest = 1'b0;
    conclude();
  end
endmodule
